// File: verilog/scc_pkg.sv
// Constants for the skip/call/clear instruction decoder.
// Assumes a 14-bit instruction word and a 13-bit program counter.
package scc_pkg;
  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int INSN_W = 14;
  localparam int PC_W   = 13;
  localparam int FADR_W = 7;
  localparam int DATA_W = 8;
  localparam int BSEL_W = 3;
  localparam int LIT_W  = 11;
  // ----------------------------------------------------------------
  // Opcode patterns and fields
  // ----------------------------------------------------------------
  localparam logic [3:0] OPC_SKIP_SET = 4'h7;  // 01 11 in bits 13:10
  localparam logic [2:0] OPC_CALL     = 3'h4;  // 10 0 in bits 13:11
  localparam logic [6:0] OPC_CLEAR    = 7'h03; // 00 0001 1 in 13:7
  localparam int SKIP_OPC_LSB = 10;
  localparam int CALL_OPC_LSB = 11;
  localparam int CLEAR_OPC_LSB = 7;
  localparam int BSEL_LSB     = 7;
  localparam int LATCH_LO     = 3;             // Upper latch bits 4:3
  localparam int LATCH_HI     = 4;
  localparam logic [PC_W-1:0] PC_ONE   = 13'h0001;
  localparam logic [PC_W-1:0] PC_RESET = 13'h0000;
  // ----------------------------------------------------------------
  // Sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SCC_EXEC  = 2'b00,
    SCC_FLUSH = 2'b01,
    SCC_CALL2 = 2'b10
  } scc_state_e;
endpackage : scc_pkg

// File: verilog/scc_decode.sv
// Executes bit-test-skip-if-set, subroutine call and clear-file-register.
// Assumes file reads are combinational on fileAddr and the fetch path
// presents the prefetched word on insnWord each cycle.
`timescale 1ns/10ps
// Behaviour
// - Skip next when tested file bit is one
// - Taken skip runs a NOP, two cycles
// - Call pushes current PC plus one
// - Call loads literal, upper bits from latch
// - Call takes exactly two cycles, one word
// - Clear writes zero and sets zero flag
module scc_decode (
  input  wire logic                        ref_clk,
  input  wire logic                        rst,
  input  wire logic [scc_pkg::INSN_W-1:0]  insnWord,
  input  wire logic [scc_pkg::DATA_W-1:0]  fileRdData,
  input  wire logic [scc_pkg::DATA_W-1:0]  pcUpperLatch,
  output logic      [scc_pkg::FADR_W-1:0]  fileAddr,
  output logic      [scc_pkg::DATA_W-1:0]  fileWrData,
  output logic                             fileWrEn,
  output logic                             zeroFlagSet,
  output logic      [scc_pkg::PC_W-1:0]    topOfStackEntry,
  output logic                             stackPush,
  output logic      [scc_pkg::PC_W-1:0]    pcOut,
  output logic                             nopExec
);
  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  scc_pkg::scc_state_e          state_r;
  logic [scc_pkg::PC_W-1:0]     pc_r;
  logic [scc_pkg::PC_W-1:0]     pcNext;
  logic                         isSkip;
  logic                         isCall;
  logic                         isClear;
  logic                         testBit;
  logic                         inExec;
  logic [scc_pkg::BSEL_W-1:0]   bitSel;

  // Gating every decode on EXEC is what turns a discarded word into a NOP
  assign inExec  = (state_r == scc_pkg::SCC_EXEC);
  assign isSkip  = inExec && insnWord[scc_pkg::INSN_W-1:
                   scc_pkg::SKIP_OPC_LSB] == scc_pkg::OPC_SKIP_SET;
  assign isCall  = inExec && insnWord[scc_pkg::INSN_W-1:
                   scc_pkg::CALL_OPC_LSB] == scc_pkg::OPC_CALL;
  assign isClear = inExec && insnWord[scc_pkg::INSN_W-1:
                   scc_pkg::CLEAR_OPC_LSB] == scc_pkg::OPC_CLEAR;
  // Bit field indexes fileRdData directly; the file field reaches fileAddr only through a register
  assign bitSel  = insnWord[scc_pkg::BSEL_LSB +: scc_pkg::BSEL_W];
  assign testBit = fileRdData[bitSel];
  assign pcNext  = pc_r + scc_pkg::PC_ONE;

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  // Second cycle of skip or call discards the prefetched word
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_r <= scc_pkg::SCC_EXEC;
    end else begin
      unique case (state_r)
        scc_pkg::SCC_EXEC: begin
          if (isCall) begin
            state_r <= scc_pkg::SCC_CALL2;
          end else if (isSkip && testBit) begin
            state_r <= scc_pkg::SCC_FLUSH;
          end
        end
        scc_pkg::SCC_FLUSH: state_r <= scc_pkg::SCC_EXEC;
        scc_pkg::SCC_CALL2: state_r <= scc_pkg::SCC_EXEC;
        default:            state_r <= scc_pkg::SCC_EXEC;
      endcase
    end
  end

  // Program counter: call target or sequential advance
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pc_r <= scc_pkg::PC_RESET;
    end else if (isCall) begin
      pc_r <= {pcUpperLatch[scc_pkg::LATCH_HI:scc_pkg::LATCH_LO],
               insnWord[scc_pkg::LIT_W-1:0]};
    end else if (state_r != scc_pkg::SCC_CALL2) begin
      pc_r <= pcNext;  // Call's flush cycle holds the new target
    end
  end
  assign pcOut = pc_r;

  // Return address push, registered at the end of the call's first cycle and seen in its second
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      stackPush       <= 1'b0;
      topOfStackEntry <= scc_pkg::PC_RESET;
    end else begin
      stackPush <= isCall;
      if (isCall) begin
        topOfStackEntry <= pcNext;
      end
    end
  end

  // File write and zero flag; skip and call never touch flags
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      fileWrEn    <= 1'b0;
      fileWrData  <= '0;
      zeroFlagSet <= 1'b0;
    end else begin
      fileWrEn    <= isClear;
      fileWrData  <= '0;
      zeroFlagSet <= isClear;
    end
  end

  // Address output registered for the write port
  // Costs a cycle of lag behind insnWord but lines up with fileWrEn
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      fileAddr <= '0;
    end else begin
      fileAddr <= insnWord[scc_pkg::FADR_W-1:0];
    end
  end

  // NOP indicator for the discarded slot
  // Fetch path uses it to drop the word it has already prefetched
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      nopExec <= 1'b0;
    end else begin
      nopExec <= isCall || (isSkip && testBit);
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence s_call_seen;
    isCall;
  endsequence

  sequence s_flush_one;
    state_r == scc_pkg::SCC_CALL2 ##1 inExec;
  endsequence

  // Taken skip: the decode edge that sends the sequencer to FLUSH
  sequence s_skip_hit;
    isSkip && testBit;
  endsequence

  // Skip outcome follows the tested bit alone
  a_skip_taken: assert property (@(posedge ref_clk)
    disable iff (rst)
    s_skip_hit |=> state_r == scc_pkg::SCC_FLUSH)
    else $error("taken skip did not flush");
  a_skip_not: assert property (@(posedge ref_clk)
    disable iff (rst)
    isSkip && !testBit |=> inExec)
    else $error("untaken skip flushed");
  a_skip_nop: assert property (@(posedge ref_clk)
    disable iff (rst)
    s_skip_hit |=> nopExec ##1 inExec)
    else $error("skip nop slot wrong");

  // Two cycles on from a taken skip the pc sits two words on
  a_skip_resume: assert property (@(posedge ref_clk)
    disable iff (rst)
    s_skip_hit |=> ##1 pcOut == $past(pcNext, 2) + scc_pkg::PC_ONE)
    else $error("taken skip resumed at wrong word");

  // A discarded slot writes nothing, pushes nothing, sets no flag
  a_flush_quiet: assert property (@(posedge ref_clk)
    disable iff (rst)
    !inExec |=> !fileWrEn && !stackPush && !zeroFlagSet)
    else $error("discarded word had an effect");

  // The NOP marker covers exactly one slot
  a_nop_single: assert property (@(posedge ref_clk)
    disable iff (rst)
    nopExec |=> !nopExec)
    else $error("nop slot lasted two cycles");

  // Return address is the word after the call
  a_call_push: assert property (@(posedge ref_clk)
    disable iff (rst)
    s_call_seen |=> stackPush && topOfStackEntry == $past(pcNext))
    else $error("call pushed wrong return");
  // The pushed return address stays put until the next call
  a_stack_kept: assert property (@(posedge ref_clk)
    disable iff (rst)
    !isCall |=> $stable(topOfStackEntry))
    else $error("return address moved without a call");
  a_call_target: assert property (@(posedge ref_clk)
    disable iff (rst)
    s_call_seen |=> pcOut[scc_pkg::LIT_W-1:0] ==
      $past(insnWord[scc_pkg::LIT_W-1:0]) &&
      pcOut[scc_pkg::PC_W-1:scc_pkg::LIT_W] ==
      $past(pcUpperLatch[scc_pkg::LATCH_HI:scc_pkg::LATCH_LO]))
    else $error("call target wrong");
  a_call_two: assert property (@(posedge ref_clk)
    disable iff (rst)
    s_call_seen |=> s_flush_one)
    else $error("call not two cycles");
  // The target is held through the discarded slot
  a_call_hold: assert property (@(posedge ref_clk)
    disable iff (rst)
    s_call_seen |=> ##1 $stable(pcOut) && inExec)
    else $error("call pc not held");

  // One push per call, seen in the flush slot only, never a second after it
  a_push_single: assert property (@(posedge ref_clk)
    disable iff (rst)
    stackPush |=> !stackPush)
    else $error("stack pushed twice");

  // Clear writes zero to the addressed register and sets Z
  a_clear_write: assert property (@(posedge ref_clk)
    disable iff (rst)
    isClear |=> fileWrEn && fileWrData == '0 && zeroFlagSet)
    else $error("clear did not write zero");
  a_clear_addr: assert property (@(posedge ref_clk)
    disable iff (rst)
    isClear |=> fileAddr == $past(insnWord[scc_pkg::FADR_W-1:0]))
    else $error("clear wrote the wrong address");

  // Skip and call leave the flags alone
  a_flags_kept: assert property (@(posedge ref_clk)
    disable iff (rst)
    (isSkip || isCall) |=> !zeroFlagSet && !fileWrEn)
    else $error("skip or call touched flags");
  // Untaken skip and plain words step the pc by one
  a_pc_step: assert property (@(posedge ref_clk)
    disable iff (rst)
    inExec && !isCall |=> pcOut == $past(pcNext))
    else $error("pc did not step by one");
endmodule : scc_decode

// File: dv/scc_decode_tb.sv
// Self-checking bench for the skip/call/clear decoder.
// Assumes scc_pkg is compiled first; the bench plays fetch and file path.
`timescale 1ns/10ps
module scc_decode_tb;
  // ----------------------------------------------------------------
  // Stimulus, observation and counters
  // ----------------------------------------------------------------
  logic                       ref_clk = 1'b0;
  logic                       rst = 1'b1;
  logic [scc_pkg::INSN_W-1:0] insnWord = 14'h0000;
  logic [scc_pkg::DATA_W-1:0] fileRdData = 8'h00;
  logic [scc_pkg::DATA_W-1:0] pcUpperLatch = 8'h00;
  logic [scc_pkg::FADR_W-1:0] fileAddr;
  logic [scc_pkg::DATA_W-1:0] fileWrData;
  logic                       fileWrEn, zeroFlagSet, stackPush, nopExec;
  logic [scc_pkg::PC_W-1:0]   topOfStackEntry, pcOut, ep;
  int                         miscompares = 0;
  int                         cmp_count = 0;
  int                         cycles = 0;
  scc_decode dut_u (.ref_clk(ref_clk), .rst(rst), .insnWord(insnWord),
    .fileRdData(fileRdData), .pcUpperLatch(pcUpperLatch),
    .fileAddr(fileAddr), .fileWrData(fileWrData), .fileWrEn(fileWrEn),
    .zeroFlagSet(zeroFlagSet), .topOfStackEntry(topOfStackEntry),
    .stackPush(stackPush), .pcOut(pcOut), .nopExec(nopExec));
  // 4 ns period
  always #2 ref_clk = ~ref_clk;
  // Hang guard, far above the 45 or so cycles the run needs
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      conclude();
    end
  end
  task automatic conclude();
    $display("Checks %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : conclude
  task automatic chk(string what, logic [15:0] seen, logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  // Inputs move 1 ns after an edge; outputs are read 1 ns after the next
  task automatic step(logic [13:0] w, logic [7:0] rd);
    insnWord = w;
    fileRdData = rd;
    @(posedge ref_clk);
    #1;
  endtask : step
  // Clear one register; the pc one past the word just run is checked too
  task automatic t_clear(logic [6:0] f);
    step({7'h03, f}, 8'ha5);
    chk("wr_en", 16'(fileWrEn), 16'h0001);
    chk("wr_data", 16'(fileWrData), 16'h0000);
    chk("wr_addr", 16'(fileAddr), 16'(f));
    chk("z_set", 16'(zeroFlagSet), 16'h0001);
    chk("pc_next", 16'(pcOut), 16'(13'(ep + 13'h0001)));
    ep = ep + 13'h0001;
  endtask : t_clear
  // Call, then a clear word that must be swallowed by the second cycle
  task automatic t_call(logic [10:0] k, logic [7:0] lat);
    pcUpperLatch = lat;
    step({3'h4, k}, 8'hff);
    chk("push", 16'(stackPush), 16'h0001);
    chk("stack_top", 16'(topOfStackEntry), 16'(13'(ep + 13'h0001)));
    chk("nop_call", 16'(nopExec), 16'h0001);
    chk("pc_call", 16'(pcOut), 16'({lat[4:3], k}));
    chk("z_call", 16'(zeroFlagSet), 16'h0000);
    step(14'h01ff, 8'h00);
    chk("flush_wr", 16'(fileWrEn), 16'h0000);
    chk("pc_hold", 16'(pcOut), 16'({lat[4:3], k}));
    chk("push_once", 16'(stackPush), 16'h0000);
    ep = {lat[4:3], k};
  endtask : t_call
  // Only the selected bit decides; the other seven carry the opposite
  task automatic t_skip(logic [2:0] b, logic set);
    logic [7:0] rd;
    rd = set ? (8'h01 << b) : ~(8'h01 << b);
    step({4'h7, b, 7'h2a}, rd);
    chk("nop", 16'(nopExec), 16'(set));
    chk("z_skip", 16'(zeroFlagSet), 16'h0000);
    chk("pc_skip", 16'(pcOut), 16'(13'(ep + 13'h0001)));
    step(14'h01ff, 8'h00);
    chk("skip_wr", 16'(fileWrEn), 16'(!set));
    chk("pc_resume", 16'(pcOut), 16'(13'(ep + 13'h0002)));
    ep = ep + 13'h0002;
  endtask : t_skip
  // Mid-run reset with a call word present: nothing may be pushed
  task automatic t_reset();
    rst = 1'b1;
    step({3'h4, 11'h123}, 8'hff);
    chk("rst_pc", 16'(pcOut), 16'h0000);
    chk("rst_push", 16'(stackPush), 16'h0000);
    chk("rst_nop", 16'(nopExec), 16'h0000);
    chk("rst_wr", 16'(fileWrEn), 16'h0000);
    rst = 1'b0;
    ep = 13'h0000;
  endtask : t_reset
  // Main sequence: back-to-back calls, every bit both ways
  initial begin
    ep = 13'h0000;
    repeat (5) @(posedge ref_clk);
    #1;
    rst = 1'b0;
    chk("pc_rst", 16'(pcOut), 16'h0000);
    t_clear(7'h55);
    t_call(11'h7ff, 8'h18);
    t_call(11'h001, 8'he7);
    t_clear(7'h00);
    for (int i = 0; i < 8; i++) begin
      t_skip(3'(i), 1'b1);
      t_skip(3'(i), 1'b0);
    end
    t_reset();
    t_clear(7'h7f);
    conclude();
  end
endmodule : scc_decode_tb
